// >>> tb/hlu_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module hlu_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [20:0] bs_rx_data_q,
  input wire logic [9:0] bs_status_q,
  input wire logic hst_req_q,
  input wire logic hst_write_q,
  input wire logic hst_addr_valid_q,
  input wire logic [14:0] hst_addr_q,
  input wire logic hst_attn_q,
  input wire logic hst_ack,
  input wire logic [20:0] hst_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire dn = hst_req_q && hst_ack;
  ////////////////////////////////////////
  property p_hold; hst_req_q && !hst_ack |=> hst_req_q; endproperty
  a_hold: assert property (p_hold) else $error("req fell");
  property p_drop; dn |=> !hst_req_q; endproperty
  a_drop: assert property (p_drop) else $error("req held");
  property p_addr; $rose(hst_req_q) |-> hst_addr_valid_q; endproperty
  a_addr: assert property (p_addr) else $error("no address");
  property p_inc;
    dn ##2 hst_addr_valid_q |-> hst_addr_q == $past(hst_addr_q, 2) + 15'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("bad address");
  property p_rx; dn && !hst_write_q |=> bs_rx_data_q == $past(hst_rdata);
  endproperty
  a_rx: assert property (p_rx) else $error("bad rx word");
  property p_ign; !dn |=> $stable(bs_rx_data_q); endproperty
  a_ign: assert property (p_ign) else $error("rx changed");
  property p_busy; hst_req_q |=> bs_status_q[0]; endproperty
  a_busy: assert property (p_busy) else $error("not busy");
  property p_attn; hst_attn_q |=> !hst_attn_q; endproperty
  a_attn: assert property (p_attn) else $error("long attn");
  cover property (dn && hst_write_q);
  cover property (dn && !hst_write_q);
  cover property (hst_attn_q);
endmodule : hlu_asserts
`default_nettype wire

// >>> tb/hlu_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module hlu_host_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic req,
  input wire logic write,
  input wire logic [14:0] addr,
  input wire logic [20:0] wdata,
  input wire logic [3:0] dly,
  output logic ack,
  output logic [20:0] rdata
);
  logic [20:0] mem [0:31];
  logic [3:0] cnt_q;
  ////////////////////////////////////////
  // Host memory answers a pending request dly+1 cycles after it is raised
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      cnt_q <= 4'h0;
      rdata <= 21'h1FFFFF;
    end else if (req && !ack && cnt_q == dly) begin
      ack <= 1'b1;
      cnt_q <= 4'h0;
      rdata <= mem[addr[4:0]];
      if (write) mem[addr[4:0]] <= wdata;
    end else begin
      ack <= 1'b0;
      cnt_q <= (req && !ack) ? cnt_q + 4'h1 : 4'h0;
      rdata <= ~rdata;
    end
  end
endmodule : hlu_host_model
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock = 1'b0, rst_n = 1'b0, bs_sel = 1'b0;
  logic [6:0] bs_chan = 7'h2A;
  logic [9:0] bs_func = 10'h000, bs_status_q;
  logic [20:0] bs_tx_data = 21'h000000, bs_rx_data_q;
  logic [20:0] hst_wdata_q, hst_rdata, rd;
  logic [14:0] hst_addr_q, last_a, ra;
  logic [3:0] dly = 4'h0;
  logic hst_req_q, hst_write_q, hst_addr_valid_q, hst_attn_q, hst_ack;
  int fail_count = 0, n_checks = 0, n_attn = 0;
  logic [39:0] rows [4] = '{{4'h0, 15'h0010, 21'h155555},
    {4'h3, 15'h0011, 21'h0AAAAA}, {4'h9, 15'h7FFF, 21'h1FFFFF},
    {4'hF, 15'h0000, 21'h000001}};
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    if (hst_addr_valid_q) last_a <= hst_addr_q;
    if (hst_attn_q) n_attn <= n_attn + 1;
  end
  hlu_host_link_unit dut (.clock(clock), .rst_n(rst_n), .chan_plug(7'h2A),
    .bs_sel(bs_sel), .bs_chan(bs_chan), .bs_tx_data(bs_tx_data),
    .bs_func(bs_func), .bs_rx_data_q(bs_rx_data_q),
    .bs_status_q(bs_status_q), .hst_req_q(hst_req_q),
    .hst_write_q(hst_write_q), .hst_addr_valid_q(hst_addr_valid_q),
    .hst_addr_q(hst_addr_q), .hst_wdata_q(hst_wdata_q),
    .hst_attn_q(hst_attn_q), .hst_ack(hst_ack), .hst_rdata(hst_rdata));
  hlu_host_model u_host (.clock(clock), .rst_n(rst_n), .req(hst_req_q),
    .write(hst_write_q), .addr(hst_addr_q), .wdata(hst_wdata_q),
    .dly(dly), .ack(hst_ack), .rdata(hst_rdata));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [20:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cmd(input int f, input logic [20:0] d);
    bs_sel = 1'b1;
    bs_func = 10'h001 << f;
    bs_tx_data = d;
    @(posedge clock) #2;
  endtask : cmd
  task automatic idle(input int n);
    bs_sel = 1'b0;
    bs_func = 10'h000;
    repeat (n) @(posedge clock) #2;
  endtask : idle
  task automatic wst(input int b, input logic v);
    for (int i = 0; i < 300 && bs_status_q[b] !== v; i++) @(posedge clock) #2;
    chk("status", 21'(bs_status_q[b]), 21'(v));
  endtask : wst
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge clock);
    #2 rst_n = 1'b1;
    idle(2);
    chk("status", 21'(bs_status_q), 21'h000004);
    $display("reset test done");
    foreach (rows[i]) begin
      {dly, ra, rd} = rows[i];
      cmd(1, 21'(ra));
      cmd(0, rd);
      cmd(2, 21'h000000);
      idle(3);
      wst(0, 1'b0);
      cmd(1, 21'(ra));
      cmd(3, 21'h000000);
      idle(3);
      wst(1, 1'b1);
      chk("rx word", bs_rx_data_q, rd);
      chk("address", 21'(last_a), 21'(ra));
      cmd(3, 21'h000000);
      idle(3);
      chk("refused read", 21'(bs_status_q), 21'h000006);
      cmd(5, 21'h000000);
      idle(3);
      chk("rx full", 21'(bs_status_q[1]), 21'h000000);
      $display("row %0d done", i);
    end
    bs_chan = 7'h15;
    cmd(4, 21'h000000);
    idle(3);
    chk("attn", 21'(n_attn), 21'h000000);
    bs_chan = 7'h2A;
    cmd(4, 21'h000000);
    idle(3);
    chk("attn", 21'(n_attn), 21'h000001);
    $display("channel test done");
    dly = 4'h2;
    cmd(1, 21'h007FF8);
    for (int i = 0; i < 16; i++) cmd(0, 21'h0A0000 + 21'(i));
    idle(3);
    chk("full", 21'(bs_status_q), 21'h000001);
    cmd(0, 21'h1FFFFF);
    cmd(2, 21'h000000);
    cmd(1, 21'h000100);
    idle(3);
    wst(0, 1'b0);
    chk("last addr", 21'(hst_addr_q), 21'h000007);
    cmd(1, 21'h000007);
    cmd(3, 21'h000000);
    idle(3);
    wst(1, 1'b1);
    chk("last word", bs_rx_data_q, 21'h0A000F);
    $display("burst test done");
    finish_test();
  end
endmodule : tb_top
bind hlu_host_link_unit hlu_asserts u_chk (.clock(clock), .rst_n(rst_n),
  .bs_rx_data_q(bs_rx_data_q), .bs_status_q(bs_status_q),
  .hst_req_q(hst_req_q), .hst_write_q(hst_write_q),
  .hst_addr_valid_q(hst_addr_valid_q), .hst_addr_q(hst_addr_q),
  .hst_attn_q(hst_attn_q), .hst_ack(hst_ack), .hst_rdata(hst_rdata));
`default_nettype wire

// >>> verilog/hlu_consts.svh
`ifndef HLU_CONSTS_SVH
`define HLU_CONSTS_SVH

// Word and address widths
`define HLU_WORD_W 21
`define HLU_ADDR_W 15
`define HLU_CHAN_W 7
`define HLU_FUNC_W 10
`define HLU_STAT_W 10
`define HLU_FIFO_DEPTH 16

// External function bits from the channel
`define HLU_FN_LOAD_DATA 0
`define HLU_FN_LOAD_ADDR 1
`define HLU_FN_START_WR 2
`define HLU_FN_START_RD 3
`define HLU_FN_HOST_ATTN 4
`define HLU_FN_TAKE_DATA 5

// External status bits to the channel
`define HLU_ST_BUSY 0
`define HLU_ST_RX_FULL 1
`define HLU_ST_TX_EMPTY 2

// Reset values
`define HLU_WORD_RST 21'h000000
`define HLU_ADDR_RST 15'h0000
`define HLU_CHAN_RST 7'h00
`define HLU_STAT_RST 10'h000
`define HLU_ADDR_ONE 15'h0001

`endif

// >>> verilog/hlu_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module hlu_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != '0);
  assign out_data = mem[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointers and fill level
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule : hlu_fifo

`default_nettype wire

// >>> verilog/hlu_host_link_unit.sv
// Contract
// - Moves 21-bit parallel words both directions
// - Address goes to host with a write word, before a read word
// - Address register spans whole host memory
// - Behaves as plug-addressed buffer selector channel
// - Busy status gates data and address loads
// - Host cannot start or steer anything
// - Host flag word polled through the unit
// - Control instruction interrupts host, traffic follows
`timescale 1ns/100ps
`default_nettype none
`include "hlu_consts.svh"

module hlu_host_link_unit #(
  parameter int WORD_W = `HLU_WORD_W,
  parameter int ADDR_W = `HLU_ADDR_W,
  parameter int FIFO_DEPTH = `HLU_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [`HLU_CHAN_W-1:0] chan_plug,
  input wire logic bs_sel,
  input wire logic [`HLU_CHAN_W-1:0] bs_chan,
  input wire logic [WORD_W-1:0] bs_tx_data,
  input wire logic [`HLU_FUNC_W-1:0] bs_func,
  output logic [WORD_W-1:0] bs_rx_data_q,
  output logic [`HLU_STAT_W-1:0] bs_status_q,
  output logic hst_req_q,
  output logic hst_write_q,
  output logic hst_addr_valid_q,
  output logic [ADDR_W-1:0] hst_addr_q,
  output logic [WORD_W-1:0] hst_wdata_q,
  output logic hst_attn_q,
  input wire logic hst_ack,
  input wire logic [WORD_W-1:0] hst_rdata
);

  hlu_pkg::hlu_state_t state_q;
  logic [`HLU_CHAN_W-1:0] chan_q;
  logic [ADDR_W-1:0] addr_q;
  logic rx_full_q;
  logic selected;
  logic busy;
  logic fn_load_data;
  logic fn_load_addr;
  logic fn_start_wr;
  logic fn_start_rd;
  logic fn_attn;
  logic fn_take;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [WORD_W-1:0] fifo_out_data;

  ////////////////////////////////////////////////////////////////////////////
  // Channel decode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chan_q <= `HLU_CHAN_RST;
    end else begin
      chan_q <= chan_plug;
    end
  end

  assign selected = bs_sel && (bs_chan == chan_q);
  assign busy = (state_q != hlu_pkg::HLU_IDLE) || !fifo_in_ready;
  assign fn_load_data = selected && bs_func[`HLU_FN_LOAD_DATA] && !busy;
  assign fn_load_addr = selected && bs_func[`HLU_FN_LOAD_ADDR] && !busy;
  assign fn_start_wr = selected && bs_func[`HLU_FN_START_WR];
  assign fn_start_rd = selected && bs_func[`HLU_FN_START_RD];
  assign fn_attn = selected && bs_func[`HLU_FN_HOST_ATTN];
  assign fn_take = selected && bs_func[`HLU_FN_TAKE_DATA];

  ////////////////////////////////////////////////////////////////////////////
  // Outgoing word buffer
  assign fifo_out_ready = (state_q == hlu_pkg::HLU_WR_DATA) && hst_ack;

  hlu_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(fn_load_data),
    .in_ready(fifo_in_ready),
    .in_data(bs_tx_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Host address register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= `HLU_ADDR_RST;
    end else if (fn_load_addr) begin
      addr_q <= bs_tx_data[ADDR_W-1:0];
    end else if (hst_req_q && hst_ack) begin
      addr_q <= addr_q + ADDR_W'(`HLU_ADDR_ONE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer, started only from the channel side
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= hlu_pkg::HLU_IDLE;
    end else begin
      case (state_q)
        hlu_pkg::HLU_IDLE: begin
          if (fn_start_wr && fifo_out_valid) begin
            state_q <= hlu_pkg::HLU_WR_ADDR;
          end else if (fn_start_rd && !rx_full_q) begin
            state_q <= hlu_pkg::HLU_RD_ADDR;
          end
        end
        hlu_pkg::HLU_WR_ADDR: begin
          if (fifo_out_valid) begin
            state_q <= hlu_pkg::HLU_WR_DATA;
          end else begin
            state_q <= hlu_pkg::HLU_IDLE;
          end
        end
        hlu_pkg::HLU_WR_DATA: begin
          if (hst_ack) begin
            state_q <= hlu_pkg::HLU_WR_ADDR;
          end
        end
        hlu_pkg::HLU_RD_ADDR: begin
          state_q <= hlu_pkg::HLU_RD_DATA;
        end
        hlu_pkg::HLU_RD_DATA: begin
          if (hst_ack) begin
            state_q <= hlu_pkg::HLU_IDLE;
          end
        end
        default: begin
          state_q <= hlu_pkg::HLU_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host address presentation
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hst_addr_valid_q <= 1'b0;
      hst_addr_q <= `HLU_ADDR_RST;
      hst_write_q <= 1'b0;
    end else begin
      hst_addr_valid_q <= 1'b0;
      if ((state_q == hlu_pkg::HLU_WR_ADDR && fifo_out_valid) ||
          state_q == hlu_pkg::HLU_RD_ADDR) begin
        hst_addr_valid_q <= 1'b1;
        hst_addr_q <= addr_q;
        hst_write_q <= (state_q == hlu_pkg::HLU_WR_ADDR);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host memory access request, the interrupt for each word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hst_req_q <= 1'b0;
      hst_wdata_q <= `HLU_WORD_RST;
    end else begin
      if (state_q == hlu_pkg::HLU_WR_ADDR && fifo_out_valid) begin
        hst_req_q <= 1'b1;
        hst_wdata_q <= fifo_out_data;
      end else if (state_q == hlu_pkg::HLU_RD_ADDR) begin
        hst_req_q <= 1'b1;
      end else if (hst_req_q && hst_ack) begin
        hst_req_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Attention to host for a control instruction
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hst_attn_q <= 1'b0;
    end else begin
      hst_attn_q <= fn_attn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Received word, used also to poll the host flag word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bs_rx_data_q <= `HLU_WORD_RST;
      rx_full_q <= 1'b0;
    end else begin
      if (state_q == hlu_pkg::HLU_RD_DATA && hst_ack) begin
        bs_rx_data_q <= hst_rdata;
        rx_full_q <= 1'b1;
      end else if (fn_take) begin
        rx_full_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status lines
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bs_status_q <= `HLU_STAT_RST;
    end else begin
      bs_status_q <= `HLU_STAT_RST;
      bs_status_q[`HLU_ST_BUSY] <= busy;
      bs_status_q[`HLU_ST_RX_FULL] <= rx_full_q;
      bs_status_q[`HLU_ST_TX_EMPTY] <= !fifo_out_valid;
    end
  end

endmodule : hlu_host_link_unit

`default_nettype wire

// >>> verilog/hlu_pkg.sv
package hlu_pkg;

  typedef enum logic [2:0] {
    HLU_IDLE,
    HLU_WR_ADDR,
    HLU_WR_DATA,
    HLU_RD_ADDR,
    HLU_RD_DATA
  } hlu_state_t;

endpackage : hlu_pkg
